/* File: bench/adc_window_trigger_input_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_window_trigger_input_ctrl_properties
    import adc_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic write_protect_on,
    input wire logic conv_done,
    input wire analog_ctrl_s analog,
    input wire logic adc_clk,
    input wire logic result_ready_event,
    input wire logic window_event,
    input wire logic window_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
    a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_sync_write_wait: assert property ($rose(penable) && psel && pwrite && !write_protect_on
        && paddr == OFS_WINDOW_MONITOR_CONFIG |-> !pready [*3] ##1 pready) else $error("sync write wait");
    a_start_single: assert property (analog.start |=> !analog.start) else $error("start too long");
    a_abort_clk_low: assert property (analog.abort |-> !adc_clk) else $error("clock not restarted");
    a_clk_high_two: assert property (@(posedge pclk) disable iff (!presetn || analog.abort)
        $rose(adc_clk) |=> adc_clk ##1 !adc_clk) else $error("adc clock shape");
    a_result_event_cause: assert property (result_ready_event |-> $past(conv_done))
        else $error("result event without done");
    a_window_event_flag: assert property (window_event |-> window_flag && $past(conv_done))
        else $error("window event without flag");
    a_gain_onehot: assert property ($onehot0(analog.gain_onehot)) else $error("gain not one-hot");
endmodule
bind adc_window_trigger_input_ctrl adc_window_trigger_input_ctrl_properties props_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .write_protect_on(write_protect_on), .conv_done(conv_done), .analog(analog),
    .adc_clk(adc_clk), .result_ready_event(result_ready_event), .window_event(window_event),
    .window_flag(window_flag));
`default_nettype wire

/* File: bench/adc_window_trigger_input_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_window_trigger_input_ctrl_tb;
    import adc_ctrl_pkg::*;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, write_protect_on = 0;
    logic conv_done = 0, pready, pslverr, adc_clk, result_ready_event, window_event, window_flag, irq, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic [RAW_W-1:0] raw_result = '0;
    analog_ctrl_s analog;
    int num_errors = 0, cmp_count = 0;
    always #20 pclk = ~pclk;
    adc_window_trigger_input_ctrl adc_window_trigger_input_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_protect_on(write_protect_on),
        .conv_done(conv_done), .raw_result(raw_result), .analog(analog), .adc_clk(adc_clk),
        .result_ready_event(result_ready_event), .window_event(window_event), .window_flag(window_flag),
        .irq(irq));
    task automatic report_and_stop();
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ============================================================
    // Bus and handshake helpers
    // ============================================================
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        apb(0, a, '0);
        chk(rd, exp);
    endtask
    task automatic wait_for(input bit ab);
        for (int n = 0; n < 40; n++) begin
            @(posedge pclk);
            if ((ab ? analog.abort : analog.start) === 1'b1)
                return;
        end
        num_errors++;
        report_and_stop();
    endtask
    task automatic convert(input logic [RAW_W-1:0] raw);
        apb(1, OFS_SOFTWARE_TRIGGER, 32'h2);
        wait_for(0);
        conv_done <= 1;
        raw_result <= raw;
        @(posedge pclk);
        conv_done <= 0;
        @(posedge pclk);
    endtask
    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_reset();
        rdc(OFS_WINDOW_MONITOR_CONFIG, 0);
        rdc(OFS_SOFTWARE_TRIGGER, 0);
        rdc(OFS_INPUT_SELECT_CONFIG, 0);
        apb(1, OFS_SOFTWARE_TRIGGER, 0);
        repeat (12) begin
            @(posedge pclk);
            chk(analog.start, 0);
        end
        write_protect_on <= 1;
        apb(1, OFS_WINDOW_MONITOR_CONFIG, 32'h3);
        chk(err, 1);
        write_protect_on <= 0;
        rdc(OFS_WINDOW_MONITOR_CONFIG, 0);
        apb(0, 12'h030, '0);
        chk(err, 1);
    endtask
    task automatic t_codes();
        for (int c = 0; c < 8; c++) begin
            apb(1, OFS_WINDOW_MONITOR_CONFIG, 32'(c));
            rdc(OFS_WINDOW_MONITOR_CONFIG, 32'(c));
        end
        for (int g = 0; g < 16; g++) begin
            apb(1, OFS_INPUT_SELECT_CONFIG, 32'(g) << SEL_GAIN_LSB);
            @(posedge pclk);
            chk(analog.gain_onehot, g < 5 ? 32'h1 << g : (g == 15 ? 32'h20 : 32'h0));
        end
    endtask
    task automatic t_conv();
        apb(1, OFS_RESULT_FORMAT, 32'hC);
        apb(1, OFS_WINDOW_LOWER_LIMIT, 32'h100);
        apb(1, OFS_WINDOW_UPPER_LIMIT, 32'h800);
        apb(1, OFS_WINDOW_MONITOR_CONFIG, 32'h3);
        apb(1, OFS_IRQ_MASK, 32'h2);
        convert(12'h123);
        chk({result_ready_event, window_event}, 2'b11);
        rdc(OFS_SOFTWARE_TRIGGER, 0);
        rdc(OFS_RESULT, 32'h123);
        chk({window_flag, irq}, 2'b11);
        apb(1, OFS_IRQ_STATUS, 32'h2);
        chk({window_flag, irq}, 0);
        apb(1, OFS_RESULT_FORMAT, 32'hF);
        @(posedge pclk);
        chk(analog.differential_select, 1);
        convert(12'hABC);
        rdc(OFS_RESULT, 32'hABC0);
        chk(window_flag, 0);
        apb(1, OFS_WINDOW_MONITOR_CONFIG, 32'h4);
        convert(12'hABC);
        chk({window_flag, irq}, 2'b11);
        rdc(OFS_IRQ_STATUS, 32'h3);
    endtask
    task automatic t_scan();
        apb(1, OFS_INPUT_SELECT_CONFIG, 32'h00020003);
        @(posedge pclk);
        chk(analog.positive_input, 3);
        for (int i = 1; i < 5; i++) begin
            convert(12'h000);
            rdc(OFS_INPUT_SELECT_CONFIG, 32'h00020003 | (32'(i % 3) << SEL_OFFSET_LSB));
            chk(analog.positive_input, 32'(3 + i % 3));
        end
    endtask
    task automatic t_flush();
        apb(1, OFS_IRQ_STATUS, 32'h7);
        apb(1, OFS_SOFTWARE_TRIGGER, 32'h2);
        wait_for(0);
        apb(1, OFS_SOFTWARE_TRIGGER, 32'h3);
        wait_for(1);
        wait_for(0);
        rdc(OFS_SOFTWARE_TRIGGER, 0);
        rdc(OFS_IRQ_STATUS, 32'h4);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset();
        t_codes();
        t_conv();
        t_scan();
        t_flush();
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: rtl/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

    // ============================================================
    // Bus and clock
    // ============================================================
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PCLK_MHZ = 25;

    // ============================================================
    // Register offsets
    // ============================================================
    localparam logic [ADDR_W-1:0] OFS_RESULT_FORMAT = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_WINDOW_MONITOR_CONFIG = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_SOFTWARE_TRIGGER = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_INPUT_SELECT_CONFIG = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_WINDOW_LOWER_LIMIT = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_WINDOW_UPPER_LIMIT = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 12'h028;

    // ============================================================
    // Field positions and widths
    // ============================================================
    localparam int unsigned FMT_DIFF_BIT = 0;
    localparam int unsigned FMT_LEFT_BIT = 1;
    localparam int unsigned FMT_WIN_EVENT_BIT = 2;
    localparam int unsigned FMT_RDY_EVENT_BIT = 3;
    localparam int unsigned TRIG_FLUSH_BIT = 0;
    localparam int unsigned TRIG_START_BIT = 1;
    localparam int unsigned SEL_POS_LSB = 0;
    localparam int unsigned SEL_NEG_LSB = 8;
    localparam int unsigned SEL_SCAN_LSB = 16;
    localparam int unsigned SEL_OFFSET_LSB = 20;
    localparam int unsigned SEL_GAIN_LSB = 24;
    localparam int unsigned MUX_W = 5;
    localparam int unsigned SCAN_W = 4;
    localparam int unsigned GAIN_W = 4;
    localparam int unsigned MODE_W = 3;
    localparam int unsigned RAW_W = 12;
    localparam int unsigned RES_W = 16;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_RESULT_BIT = 0;
    localparam int unsigned IRQ_WINDOW_BIT = 1;
    localparam int unsigned IRQ_FLUSH_BIT = 2;

    // ============================================================
    // Reset values
    // ============================================================
    localparam logic [3:0] RESET_RESULT_FORMAT = 4'h0;
    localparam logic [MODE_W-1:0] RESET_WINDOW_MONITOR_CONFIG = 3'h0;
    localparam logic [1:0] RESET_SOFTWARE_TRIGGER = 2'h0;
    localparam logic [DATA_W-1:0] RESET_INPUT_SELECT_CONFIG = 32'h00000000;
    localparam logic [RES_W-1:0] RESET_LIMIT = 16'h0000;
    localparam logic [IRQ_W-1:0] RESET_IRQ = 3'h0;

    // ============================================================
    // Timing
    // ============================================================
    localparam int unsigned SYNC_TIME_NS = 120;
    localparam int unsigned SYNC_CYCLES = (SYNC_TIME_NS * PCLK_MHZ + 999) / 1000;
    localparam logic [1:0] SYNC_LOAD = 2'(SYNC_CYCLES - 1);
    localparam int unsigned ADC_CLK_DIV = 4;
    localparam logic [1:0] DIV_LAST = 2'(ADC_CLK_DIV - 1);
    localparam logic [1:0] DIV_HALF = 2'(ADC_CLK_DIV / 2);

    // ============================================================
    // Codes and types
    // ============================================================
    localparam logic [GAIN_W-1:0] GAIN_1X = 4'h0;
    localparam logic [GAIN_W-1:0] GAIN_2X = 4'h1;
    localparam logic [GAIN_W-1:0] GAIN_4X = 4'h2;
    localparam logic [GAIN_W-1:0] GAIN_8X = 4'h3;
    localparam logic [GAIN_W-1:0] GAIN_16X = 4'h4;
    localparam logic [GAIN_W-1:0] GAIN_HALF = 4'hF;

    typedef enum logic [2:0] {
        WIN_OFF = 3'b000,
        WIN_ABOVE = 3'b001,
        WIN_BELOW = 3'b010,
        WIN_INSIDE = 3'b011,
        WIN_OUTSIDE = 3'b100
    } window_mode_e;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_BUSY = 2'b01,
        CONV_FLUSH = 2'b10
    } conv_state_e;

    // Gain one-hot: bit0 1x .. bit4 16x, bit5 half gain
    typedef struct packed {
        logic start;
        logic abort;
        logic differential_select;
        logic [MUX_W-1:0] positive_input;
        logic [MUX_W-1:0] negative_input;
        logic [5:0] gain_onehot;
    } analog_ctrl_s;

endpackage

/* File: rtl/adc_window_trigger_input_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Alignment zero: result right-justified
// - Alignment one: 12-bit result left-justified
// - Differential bit selects positive minus negative
// - Window mode decode, codes five-seven reserved
// - Writing one to start begins conversion
// - Start bit clears when conversion begins
// - Start written during a conversion queues one more
// - Flush aborts conversions, discarding results
// - Flush restarts divided conversion clock
// - Flush bit clears when flush completes
// - After flush, pending request starts fresh
// - Gain decode, half gain, reserved codes
// - Nonzero scan count enables pin scanning
// - Positive input is selection plus offset
// - Offset increments after each completed conversion
// - Protected registers; accepted writes synchronized
// - Scan covers count plus one inputs
// - Window hit raises flag and event
module adc_window_trigger_input_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_protect_on,
    input wire logic conv_done,
    input wire logic [RAW_W-1:0] raw_result,
    output analog_ctrl_s analog,
    output logic adc_clk,
    output logic result_ready_event,
    output logic window_event,
    output logic window_flag,
    output logic irq
);

    // ============================================================
    // Register state
    // ============================================================
    logic result_left_align;
    logic differential_select;
    logic window_event_enable;
    logic ready_event_enable;
    logic [MODE_W-1:0] window_compare_mode;
    logic start_bit;
    logic flush_bit;
    logic [MUX_W-1:0] positive_input_select;
    logic [MUX_W-1:0] negative_input_select;
    logic [SCAN_W-1:0] scan_channel_count;
    logic [SCAN_W-1:0] scan_position_offset;
    logic [GAIN_W-1:0] gain_select;
    logic [RES_W-1:0] window_lower_limit;
    logic [RES_W-1:0] window_upper_limit;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [RES_W-1:0] result_value;

    // ============================================================
    // Bus decode
    // ============================================================
    logic bus_setup;
    logic bus_done;
    logic wr_commit;
    logic hit_format, hit_window, hit_trigger, hit_select;
    logic hit_lower, hit_upper, hit_status, hit_mask, hit_result;
    logic addr_mapped;
    logic target_protected;
    logic access_error;
    logic [1:0] sync_cnt;
    logic [DATA_W-1:0] read_value;

    assign bus_setup = psel & ~penable;
    assign bus_done = psel & penable & pready;
    assign wr_commit = bus_done & pwrite & ~pslverr;

    assign hit_format = (paddr == OFS_RESULT_FORMAT);
    assign hit_window = (paddr == OFS_WINDOW_MONITOR_CONFIG);
    assign hit_trigger = (paddr == OFS_SOFTWARE_TRIGGER);
    assign hit_select = (paddr == OFS_INPUT_SELECT_CONFIG);
    assign hit_lower = (paddr == OFS_WINDOW_LOWER_LIMIT);
    assign hit_upper = (paddr == OFS_WINDOW_UPPER_LIMIT);
    assign hit_status = (paddr == OFS_IRQ_STATUS);
    assign hit_mask = (paddr == OFS_IRQ_MASK);
    assign hit_result = (paddr == OFS_RESULT);
    assign addr_mapped = hit_format | hit_window | hit_trigger | hit_select | hit_lower | hit_upper
                         | hit_status | hit_mask | hit_result;
    assign target_protected = hit_window | hit_trigger | hit_select;
    assign access_error = ~addr_mapped | (pwrite & target_protected & write_protect_on);

    always_comb begin
        read_value = '0;
        if (hit_format) begin
            read_value[FMT_DIFF_BIT] = differential_select;
            read_value[FMT_LEFT_BIT] = result_left_align;
            read_value[FMT_WIN_EVENT_BIT] = window_event_enable;
            read_value[FMT_RDY_EVENT_BIT] = ready_event_enable;
        end
        if (hit_window) begin
            read_value[MODE_W-1:0] = window_compare_mode;
        end
        if (hit_trigger) begin
            read_value[TRIG_START_BIT] = start_bit;
            read_value[TRIG_FLUSH_BIT] = flush_bit;
        end
        if (hit_select) begin
            read_value[SEL_POS_LSB +: MUX_W] = positive_input_select;
            read_value[SEL_NEG_LSB +: MUX_W] = negative_input_select;
            read_value[SEL_SCAN_LSB +: SCAN_W] = scan_channel_count;
            read_value[SEL_OFFSET_LSB +: SCAN_W] = scan_position_offset;
            read_value[SEL_GAIN_LSB +: GAIN_W] = gain_select;
        end
        if (hit_lower) begin
            read_value[RES_W-1:0] = window_lower_limit;
        end
        if (hit_upper) begin
            read_value[RES_W-1:0] = window_upper_limit;
        end
        if (hit_status) begin
            read_value[IRQ_W-1:0] = irq_status;
        end
        if (hit_mask) begin
            read_value[IRQ_W-1:0] = irq_mask;
        end
        if (hit_result) begin
            read_value[RES_W-1:0] = result_value;
        end
    end

    // ============================================================
    // APB handshake; synchronized writes stall the access phase
    // ============================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            sync_cnt <= '0;
        end else if (clk_en) begin
            if (bus_done) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end else if (bus_setup) begin
                prdata <= pwrite ? '0 : read_value;
                pslverr <= access_error;
                if (pwrite && target_protected && !access_error) begin
                    sync_cnt <= SYNC_LOAD;
                    pready <= 1'b0;
                end else begin
                    pready <= 1'b1;
                end
            end else if (psel && penable && !pready) begin
                if (sync_cnt == 2'h0) begin
                    pready <= 1'b1;
                end else begin
                    sync_cnt <= sync_cnt - 2'h1;
                end
            end
        end
    end

    // ============================================================
    // Conversion clock divider and sequencer
    // ============================================================
    conv_state_e state;
    conv_state_e next_state;
    logic [1:0] div_cnt;
    logic adc_tick;
    logic conv_begin;
    logic conv_complete;
    logic flush_done;

    assign adc_tick = (div_cnt == DIV_LAST);

    always_comb begin
        next_state = state;
        conv_begin = 1'b0;
        conv_complete = 1'b0;
        flush_done = 1'b0;
        case (state)
            CONV_IDLE: begin
                if (flush_bit) begin
                    next_state = CONV_FLUSH;
                end else if (start_bit && adc_tick) begin
                    conv_begin = 1'b1;
                    next_state = CONV_BUSY;
                end
            end
            CONV_BUSY: begin
                if (flush_bit) begin
                    next_state = CONV_FLUSH;
                end else if (conv_done) begin
                    conv_complete = 1'b1;
                    next_state = CONV_IDLE;
                end
            end
            CONV_FLUSH: begin
                flush_done = 1'b1;
                next_state = CONV_IDLE;
            end
            default: begin
                next_state = CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CONV_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
            adc_clk <= 1'b0;
        end else if (clk_en) begin
            if (flush_done) begin
                div_cnt <= '0;
                adc_clk <= 1'b0;
            end else begin
                div_cnt <= adc_tick ? 2'h0 : div_cnt + 2'h1;
                adc_clk <= (div_cnt >= DIV_HALF - 2'h1) && (div_cnt < DIV_LAST);
            end
        end
    end

    // ============================================================
    // Configuration registers
    // ============================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ready_event_enable, window_event_enable, result_left_align, differential_select} <= RESET_RESULT_FORMAT;
            window_compare_mode <= RESET_WINDOW_MONITOR_CONFIG;
            window_lower_limit <= RESET_LIMIT;
            window_upper_limit <= RESET_LIMIT;
            irq_mask <= RESET_IRQ;
        end else if (clk_en && wr_commit) begin
            if (hit_format) begin
                differential_select <= pwdata[FMT_DIFF_BIT];
                result_left_align <= pwdata[FMT_LEFT_BIT];
                window_event_enable <= pwdata[FMT_WIN_EVENT_BIT];
                ready_event_enable <= pwdata[FMT_RDY_EVENT_BIT];
            end
            if (hit_window) begin
                window_compare_mode <= pwdata[MODE_W-1:0];
            end
            if (hit_lower) begin
                window_lower_limit <= pwdata[RES_W-1:0];
            end
            if (hit_upper) begin
                window_upper_limit <= pwdata[RES_W-1:0];
            end
            if (hit_mask) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ============================================================
    // Software trigger: start and flush
    // ============================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {start_bit, flush_bit} <= RESET_SOFTWARE_TRIGGER;
        end else if (clk_en) begin
            if (conv_begin) begin
                start_bit <= 1'b0;
            end else if (wr_commit && hit_trigger && pwdata[TRIG_START_BIT]) begin
                start_bit <= 1'b1;
            end
            if (wr_commit && hit_trigger && pwdata[TRIG_FLUSH_BIT]) begin
                flush_bit <= 1'b1;
            end else if (flush_done) begin
                flush_bit <= 1'b0;
            end
        end
    end

    // ============================================================
    // Input selection and scan offset
    // ============================================================
    logic scan_enabled;
    logic scan_at_end;

    assign scan_enabled = (scan_channel_count != '0);
    assign scan_at_end = (scan_position_offset >= scan_channel_count);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            positive_input_select <= RESET_INPUT_SELECT_CONFIG[SEL_POS_LSB +: MUX_W];
            negative_input_select <= RESET_INPUT_SELECT_CONFIG[SEL_NEG_LSB +: MUX_W];
            scan_channel_count <= RESET_INPUT_SELECT_CONFIG[SEL_SCAN_LSB +: SCAN_W];
            scan_position_offset <= RESET_INPUT_SELECT_CONFIG[SEL_OFFSET_LSB +: SCAN_W];
            gain_select <= RESET_INPUT_SELECT_CONFIG[SEL_GAIN_LSB +: GAIN_W];
        end else if (clk_en) begin
            if (wr_commit && hit_select) begin
                positive_input_select <= pwdata[SEL_POS_LSB +: MUX_W];
                negative_input_select <= pwdata[SEL_NEG_LSB +: MUX_W];
                scan_channel_count <= pwdata[SEL_SCAN_LSB +: SCAN_W];
                scan_position_offset <= pwdata[SEL_OFFSET_LSB +: SCAN_W];
                gain_select <= pwdata[SEL_GAIN_LSB +: GAIN_W];
            end else if (conv_complete && scan_enabled) begin
                if (scan_at_end) begin
                    scan_position_offset <= '0;
                end else begin
                    scan_position_offset <= scan_position_offset + 4'h1;
                end
            end
        end
    end

    // ============================================================
    // Analog front-end controls
    // ============================================================
    function automatic logic [5:0] gain_decode(input logic [GAIN_W-1:0] code);
        case (code)
            GAIN_1X: gain_decode = 6'h01;
            GAIN_2X: gain_decode = 6'h02;
            GAIN_4X: gain_decode = 6'h04;
            GAIN_8X: gain_decode = 6'h08;
            GAIN_16X: gain_decode = 6'h10;
            GAIN_HALF: gain_decode = 6'h20;
            default: gain_decode = 6'h00;
        endcase
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog <= '0;
        end else if (clk_en) begin
            analog.start <= conv_begin;
            analog.abort <= flush_done;
            analog.differential_select <= differential_select;
            analog.positive_input <= MUX_W'(positive_input_select + MUX_W'(scan_position_offset));
            analog.negative_input <= negative_input_select;
            analog.gain_onehot <= gain_decode(gain_select);
        end
    end

    // ============================================================
    // Result formatting and window monitor
    // ============================================================
    function automatic logic window_match(
        input logic [MODE_W-1:0] mode,
        input logic [RES_W-1:0] value,
        input logic [RES_W-1:0] lower,
        input logic [RES_W-1:0] upper
    );
        case (window_mode_e'(mode))
            WIN_ABOVE: window_match = (value > lower);
            WIN_BELOW: window_match = (value < upper);
            WIN_INSIDE: window_match = (value > lower) && (value < upper);
            WIN_OUTSIDE: window_match = !((value > lower) && (value < upper));
            default: window_match = 1'b0;
        endcase
    endfunction

    logic [RES_W-1:0] raw_right;
    logic window_hit;

    assign raw_right = {4'h0, raw_result};
    assign window_hit = conv_complete && window_match(window_compare_mode, raw_right,
                                                      window_lower_limit, window_upper_limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_value <= '0;
        end else if (clk_en && conv_complete) begin
            if (result_left_align) begin
                result_value <= {raw_result, 4'h0};
            end else begin
                result_value <= raw_right;
            end
        end
    end

    // ============================================================
    // Events and interrupt
    // ============================================================
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clear;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_RESULT_BIT] = conv_complete;
        irq_set[IRQ_WINDOW_BIT] = window_hit;
        irq_set[IRQ_FLUSH_BIT] = flush_done;
        irq_clear = (wr_commit && hit_status) ? pwdata[IRQ_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= RESET_IRQ;
            irq <= 1'b0;
            window_flag <= 1'b0;
            result_ready_event <= 1'b0;
            window_event <= 1'b0;
        end else if (clk_en) begin
            irq_status <= (irq_status & ~irq_clear) | irq_set;
            irq <= |(((irq_status & ~irq_clear) | irq_set) & irq_mask);
            window_flag <= ((irq_status[IRQ_WINDOW_BIT] & ~irq_clear[IRQ_WINDOW_BIT]) | window_hit);
            result_ready_event <= conv_complete & ready_event_enable;
            window_event <= window_hit & window_event_enable;
        end
    end

endmodule
`default_nettype wire
